// ### verilog/switch_monitor_pkg.sv
// Package with the constants shared by the switch monitor serial port.
package switch_monitor_pkg;

  // ===========================================================================
  // Word layout
  // ===========================================================================
  localparam int WORD_BITS     = 24;
  localparam int PROG_COUNT    = 8;
  localparam int GND_COUNT     = 14;
  localparam int SW_COUNT      = PROG_COUNT + GND_COUNT;
  localparam int SW_LSB        = 0;
  localparam int RESET_FLAG_POS = 22;
  localparam int THERMAL_FLAG_POS = 23;
  localparam int CMD_SEL_POS   = 16;

  // Command code held in the top byte that loads the battery/ground select byte.
  localparam logic [7:0] CMD_SETTINGS = 8'h01;
  // Battery type is the state after reset on every programmable input.
  localparam logic [PROG_COUNT-1:0] PROG_TYPE_RESET = 8'hff;

  // ===========================================================================
  // Mode
  // ===========================================================================
  typedef enum logic {MODE_NORMAL, MODE_SLEEP} mode_e;

endpackage : switch_monitor_pkg

// ### verilog/pin_sync.sv
// Two-stage synchroniser for a bundle of asynchronous input levels.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  // Reset value is all ones: the link pins idle high except the clock, which
  // settles within two cycles anyway.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule // pin_sync

// ### verilog/switch_monitor_serial_port.sv
// Serial slave port, interrupt and wake logic of the switch monitor.
`timescale 1ns/100ps
module switch_monitor_serial_port
  import switch_monitor_pkg::*;
#(
  parameter int WORD_WIDTH = WORD_BITS
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  // Serial link pins
  input  wire logic                  chip_select_n,
  input  wire logic                  serial_clk,
  input  wire logic                  serial_in,
  output logic                       serial_out,
  output logic                       serial_out_oe,
  // Open-drain interrupt line
  input  wire logic                  int_n_in,
  output logic                       int_n_out,
  output logic                       int_n_oe,
  // Open-drain wake line
  input  wire logic                  wake_n_in,
  output logic                       wake_n_out,
  output logic                       wake_n_oe,
  // Comparator levels: one means input above the threshold
  input  wire logic [PROG_COUNT-1:0] programmable_switch_inputs,
  input  wire logic [GND_COUNT-1:0]  ground_only_switch_inputs,
  // Device state
  input  wire logic                  logic_supply_ok,
  input  wire logic                  thermal_flag,
  input  wire logic                  int_enable,
  input  wire logic                  sleep_request,
  // Command hand-off
  output logic [WORD_WIDTH-1:0]      command_word,
  output logic                       command_valid,
  output logic [PROG_COUNT-1:0]      prog_type
);

  if (WORD_WIDTH != WORD_BITS) begin : g_bad_width
    $error("WORD_WIDTH must equal the 24-bit word");
  end

  // ===========================================================================
  // Synchronisers
  // ===========================================================================
  localparam int PIN_COUNT = 5 + PROG_COUNT + GND_COUNT + 3;
  logic [PIN_COUNT-1:0] pin_sync_out;

  pin_sync #(.WIDTH(PIN_COUNT)) u_pin_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in ({chip_select_n, serial_clk, serial_in, int_n_in, wake_n_in,
                programmable_switch_inputs, ground_only_switch_inputs,
                logic_supply_ok, thermal_flag, int_enable}),
    .sync_out (pin_sync_out)
  );

  logic                  cs_n_s;
  logic                  sclk_s;
  logic                  si_s;
  logic                  int_line_s;
  logic                  wake_line_s;
  logic [PROG_COUNT-1:0] prog_s;
  logic [GND_COUNT-1:0]  gnd_s;
  logic                  vdd_s;
  logic                  therm_s;
  logic                  int_en_s;

  assign {cs_n_s, sclk_s, si_s, int_line_s, wake_line_s, prog_s, gnd_s,
          vdd_s, therm_s, int_en_s} = pin_sync_out;

  // ===========================================================================
  // Switch decoding
  // ===========================================================================
  // Turns comparator levels into closed-is-one switch states.
  function automatic logic [SW_COUNT-1:0] decode_switches(
    input logic [PROG_COUNT-1:0] prog_lvl,
    input logic [GND_COUNT-1:0]  gnd_lvl,
    input logic [PROG_COUNT-1:0] battery_type
  );
    logic [SW_COUNT-1:0] res;
    res = '0;
    for (int i = 0; i < PROG_COUNT; i++) begin
      res[GND_COUNT+i] = battery_type[i] ? prog_lvl[i] : ~prog_lvl[i];
    end
    res[GND_COUNT-1:0] = ~gnd_lvl;
    return res;
  endfunction

  // ===========================================================================
  // State
  // ===========================================================================
  // Switch changes are ignored until the synchronisers and the previous-state
  // register hold real pin levels, so leaving reset cannot raise a false interrupt.
  localparam int SETTLE_W = 3;
  logic                  cs_n_d_ff;
  logic                  sclk_d_ff;
  logic                  wake_d_ff;
  logic                  int_d_ff;
  logic [WORD_WIDTH-1:0] shift_ff;
  logic                  so_ff;
  logic                  so_oe_ff;
  logic                  int_low_ff;
  logic                  change_in_frame_ff;
  logic                  int_latched_ff;
  logic                  reset_flag_ff;
  logic [SW_COUNT-1:0]   prev_sw_ff;
  logic [PROG_COUNT-1:0] prog_type_ff;
  logic [WORD_WIDTH-1:0] command_ff;
  logic                  command_valid_ff;
  mode_e                 mode_ff;
  logic                  wake_oe_ff;
  logic [SETTLE_W-1:0]   settle_ff;

  logic                  nxt_so;
  logic                  nxt_so_oe;
  logic                  nxt_int_low;
  logic                  nxt_change_in_frame;
  logic                  nxt_int_latched;
  logic                  nxt_reset_flag;
  logic [WORD_WIDTH-1:0] nxt_shift;
  logic [SW_COUNT-1:0]   nxt_prev_sw;
  logic [PROG_COUNT-1:0] nxt_prog_type;
  logic [WORD_WIDTH-1:0] nxt_command;
  logic                  nxt_command_valid;
  mode_e                 nxt_mode;
  logic                  nxt_wake_oe;
  logic [SETTLE_W-1:0]   nxt_settle;

  logic                  cs_fall;
  logic                  cs_rise;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  int_fall;
  logic                  wake_fall;
  logic                  sw_change;
  logic [SW_COUNT-1:0]   sw_now;
  logic [WORD_WIDTH-1:0] status_word;

  assign cs_fall   = cs_n_d_ff & ~cs_n_s;
  assign cs_rise   = ~cs_n_d_ff & cs_n_s;
  assign sclk_rise = ~sclk_d_ff & sclk_s & ~cs_n_s;
  assign sclk_fall = sclk_d_ff & ~sclk_s & ~cs_n_s;
  assign int_fall  = int_d_ff & ~int_line_s;
  assign wake_fall = wake_d_ff & ~wake_line_s;
  assign sw_now    = decode_switches(prog_s, gnd_s, prog_type_ff);
  assign sw_change = settle_ff[SETTLE_W-1] & (sw_now != prev_sw_ff);

  always_comb begin
    status_word = '0;
    status_word[SW_LSB +: SW_COUNT] = sw_now;
    status_word[RESET_FLAG_POS]     = reset_flag_ff;
    status_word[THERMAL_FLAG_POS]   = therm_s;
  end

  // ===========================================================================
  // Shift register and command
  // ===========================================================================
  always_comb begin
    nxt_shift         = shift_ff;
    nxt_so            = so_ff;
    nxt_so_oe         = so_oe_ff;
    nxt_command       = command_ff;
    nxt_command_valid = 1'b0;
    nxt_prog_type     = prog_type_ff;
    nxt_reset_flag    = reset_flag_ff;
    if (cs_fall) begin
      nxt_shift = status_word;
      nxt_so_oe = 1'b1;
    end else if (cs_rise) begin
      nxt_so_oe         = 1'b0;
      nxt_command       = shift_ff;
      nxt_command_valid = 1'b1;
      nxt_reset_flag    = 1'b0;
      if (mode_ff == MODE_NORMAL && shift_ff[WORD_WIDTH-1:CMD_SEL_POS] == CMD_SETTINGS) begin
        nxt_prog_type = shift_ff[PROG_COUNT-1:0];
      end
    end else if (sclk_rise) begin
      nxt_so = shift_ff[WORD_WIDTH-1];
    end else if (sclk_fall) begin
      nxt_shift = {shift_ff[WORD_WIDTH-2:0], si_s};
    end
  end

  // ===========================================================================
  // Interrupt and mode
  // ===========================================================================
  always_comb begin
    nxt_int_low         = int_low_ff;
    nxt_change_in_frame = change_in_frame_ff;
    nxt_int_latched     = int_latched_ff;
    nxt_prev_sw         = sw_now;
    nxt_mode            = mode_ff;
    nxt_settle          = {settle_ff[SETTLE_W-2:0], 1'b1};
    if (cs_fall) begin
      nxt_int_latched     = int_line_s;
      nxt_change_in_frame = 1'b0;
    end
    if (sw_change && !cs_n_s) begin
      nxt_change_in_frame = 1'b1;
    end
    if (cs_rise) begin
      nxt_int_low = int_low_ff & change_in_frame_ff;
    end
    if (mode_ff == MODE_NORMAL && int_en_s && sw_change) begin
      nxt_int_low = 1'b1;
    end
    if (mode_ff == MODE_SLEEP) begin
      if (vdd_s && cs_fall) begin
        nxt_mode = MODE_NORMAL;
      end
      if (vdd_s && wake_line_s && int_fall) begin
        nxt_mode = MODE_NORMAL;
      end
      if (wake_fall && (int_line_s || !vdd_s)) begin
        nxt_mode = MODE_NORMAL;
      end
      if (int_en_s && sw_change) begin
        nxt_mode = MODE_NORMAL;
      end
    end else if (sleep_request && cs_n_s) begin
      nxt_mode = MODE_SLEEP;
    end
    nxt_wake_oe = (nxt_mode == MODE_NORMAL);
  end

  // ===========================================================================
  // Registers
  // ===========================================================================
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cs_n_d_ff          <= 1'b1;
      sclk_d_ff          <= 1'b0;
      wake_d_ff          <= 1'b1;
      int_d_ff           <= 1'b1;
      shift_ff           <= '0;
      so_ff              <= 1'b0;
      so_oe_ff           <= 1'b0;
      int_low_ff         <= 1'b0;
      change_in_frame_ff <= 1'b0;
      int_latched_ff     <= 1'b1;
      reset_flag_ff      <= 1'b1;
      prev_sw_ff         <= '0;
      prog_type_ff       <= PROG_TYPE_RESET;
      command_ff         <= '0;
      command_valid_ff   <= 1'b0;
      mode_ff            <= MODE_NORMAL;
      wake_oe_ff         <= 1'b1;
      settle_ff          <= '0;
    end else begin
      cs_n_d_ff          <= cs_n_s;
      sclk_d_ff          <= sclk_s;
      wake_d_ff          <= wake_line_s;
      int_d_ff           <= int_line_s;
      shift_ff           <= nxt_shift;
      so_ff              <= nxt_so;
      so_oe_ff           <= nxt_so_oe;
      int_low_ff         <= nxt_int_low;
      change_in_frame_ff <= nxt_change_in_frame;
      int_latched_ff     <= nxt_int_latched;
      reset_flag_ff      <= nxt_reset_flag;
      prev_sw_ff         <= nxt_prev_sw;
      prog_type_ff       <= nxt_prog_type;
      command_ff         <= nxt_command;
      command_valid_ff   <= nxt_command_valid;
      mode_ff            <= nxt_mode;
      wake_oe_ff         <= nxt_wake_oe;
      settle_ff          <= nxt_settle;
    end
  end

  // ===========================================================================
  // Outputs
  // ===========================================================================
  assign serial_out    = so_ff;
  assign serial_out_oe = so_oe_ff;
  assign int_n_out     = 1'b0;
  assign int_n_oe      = int_low_ff;
  assign wake_n_out    = 1'b0;
  // Wake line is pulled low in normal mode only.
  assign wake_n_oe     = wake_oe_ff;
  assign command_word  = command_ff;
  assign command_valid = command_valid_ff;
  assign prog_type     = prog_type_ff;

endmodule // switch_monitor_serial_port

// ### verification/switch_monitor_sva.sv
// Concurrent checks on the pins of the switch monitor serial port.
`timescale 1ns/100ps
module switch_monitor_sva
  import switch_monitor_pkg::*;
#(
  parameter int WORD_WIDTH = WORD_BITS
) (
  // Clock and reset
  input wire logic                  sys_clk,
  input wire logic                  reset,
  // Link and open-drain pins
  input wire logic                  chip_select_n,
  input wire logic                  serial_clk,
  input wire logic                  serial_out,
  input wire logic                  serial_out_oe,
  input wire logic                  int_n_out,
  input wire logic                  int_n_oe,
  input wire logic                  wake_n_out,
  input wire logic                  wake_n_oe,
  // State and command
  input wire logic                  logic_supply_ok,
  input wire logic [WORD_WIDTH-1:0] command_word,
  input wire logic                  command_valid,
  input wire logic [PROG_COUNT-1:0] prog_type
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_sel_fall; $fell(chip_select_n) && logic_supply_ok && wake_n_oe; endsequence
  sequence s_sel_rise; $rose(chip_select_n); endsequence

  property p_oe_on; s_sel_fall |-> ##[1:5] serial_out_oe; endproperty
  property p_oe_off; s_sel_rise |-> ##[1:6] !serial_out_oe; endproperty
  property p_idle; chip_select_n [*6] |-> !serial_out_oe; endproperty
  property p_pulse; command_valid |=> !command_valid; endproperty
  property p_cause; $rose(command_valid) |-> chip_select_n && !$past(chip_select_n, 8); endproperty
  property p_word; $changed(command_word) |-> ##[0:1] command_valid; endproperty
  property p_type; $changed(prog_type) |-> command_valid || $past(command_valid); endproperty
  property p_drain; !int_n_out && !wake_n_out; endproperty
  property p_int_clr; $fell(int_n_oe) |-> chip_select_n; endproperty
  property p_sleep; $fell(wake_n_oe) |-> chip_select_n; endproperty
  property p_shift;
    serial_out_oe && $past(serial_out_oe) && $changed(serial_out) |-> $past(serial_clk, 2);
  endproperty

  a_oe_on: assert property (p_oe_on)
    else $error("output not enabled after select fall");
  a_oe_off: assert property (p_oe_off)
    else $error("output not released after select rise");
  a_idle: assert property (p_idle)
    else $error("output driven while select high");
  a_pulse: assert property (p_pulse)
    else $error("command pulse longer than one cycle");
  a_cause: assert property (p_cause)
    else $error("command taken without a select rise");
  a_word: assert property (p_word)
    else $error("command word moved without a pulse");
  a_type: assert property (p_type)
    else $error("input type moved without a command");
  a_drain: assert property (p_drain)
    else $error("open-drain output driven high");
  a_int_clr: assert property (p_int_clr)
    else $error("interrupt released while select low");
  a_sleep: assert property (p_sleep)
    else $error("sleep entered while select low");
  a_shift: assert property (p_shift)
    else $error("output bit moved without a clock rise");
endmodule // switch_monitor_sva

bind switch_monitor_serial_port switch_monitor_sva #(.WORD_WIDTH(WORD_WIDTH)) u_sva (
  .sys_clk, .reset, .chip_select_n, .serial_clk, .serial_out, .serial_out_oe, .int_n_out,
  .int_n_oe, .wake_n_out, .wake_n_oe, .logic_supply_ok, .command_word, .command_valid,
  .prog_type
);

// ### verification/spi_host_model.sv
// Host controller model that runs 24-bit frames on the serial link.
`timescale 1ns/100ps
module spi_host_model (
  // Clock used only to place the start of a frame
  input wire logic sys_clk,
  // Link pins
  input wire logic so_wire,
  output logic     chip_select_n,
  output logic     serial_clk,
  output logic     serial_in
);
  localparam realtime HALF = 80;

  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end

  // Select moves only with the clock low and every frame is whole.
  task automatic transfer(input logic [23:0] tx, output logic [23:0] rx);
    @(posedge sys_clk);
    #1 chip_select_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      #(HALF) serial_clk = 1'b1;
      serial_in = tx[i];
      #(HALF) serial_clk = 1'b0;
      rx[i] = so_wire;
    end
    #(HALF) chip_select_n = 1'b1;
    serial_in = ~serial_in;
    #(HALF);
  endtask

  // Clock and data activity while not selected.
  task automatic noise;
    repeat (3) begin
      #(HALF) serial_clk = 1'b1;
      serial_in = ~serial_in;
      #(HALF) serial_clk = 1'b0;
    end
  endtask
endmodule // spi_host_model

// ### verification/tb.sv
// Self-checking bench for the switch monitor serial port.
`timescale 1ns/100ps
module tb
  import switch_monitor_pkg::*;
;
  logic        sys_clk, reset, serial_out, serial_out_oe, int_n_out, int_n_oe;
  logic        wake_n_out, wake_n_oe, int_pull, wake_pull, supply, therm, int_en, sleep_req;
  logic        cmd_valid;
  logic [7:0]  prog, ptype;
  logic [13:0] gnd;
  logic [23:0] cmd_word, rx;
  wire         chip_select_n, serial_clk, serial_in;
  wire         so_wire = serial_out_oe ? serial_out : ~serial_out;
  wire         int_n_in = !(int_n_oe || int_pull);
  wire         wake_n_in = !(wake_n_oe || wake_pull);
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cycles = 0;

  switch_monitor_serial_port dut (
    .sys_clk, .reset, .chip_select_n, .serial_clk, .serial_in, .serial_out, .serial_out_oe,
    .int_n_in, .int_n_out, .int_n_oe, .wake_n_in, .wake_n_out, .wake_n_oe,
    .programmable_switch_inputs(prog), .ground_only_switch_inputs(gnd),
    .logic_supply_ok(supply), .thermal_flag(therm), .int_enable(int_en),
    .sleep_request(sleep_req), .command_word(cmd_word), .command_valid(cmd_valid),
    .prog_type(ptype)
  );
  spi_host_model host (.sys_clk, .so_wire, .chip_select_n, .serial_clk, .serial_in);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wclk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Closed reads one: battery type follows the level, ground type inverts it.
  function automatic logic [23:0] status(input logic rf, input logic [7:0] pt);
    return {therm, rf, pt ~^ prog, ~gnd};
  endfunction

  task automatic t_transfer;
    check("reset type", {16'h0, ptype}, {16'h0, PROG_TYPE_RESET});
    host.transfer({CMD_SETTINGS, 16'h003c}, rx);
    check("status after reset", rx, status(1'b1, 8'hff));
    wclk(6);
    check("settings word", cmd_word, {CMD_SETTINGS, 16'h003c});
    check("new type", {16'h0, ptype}, 24'h3c);
    check("output off", {23'h0, serial_out_oe}, 24'h0);
    therm = 1'b0;
    gnd = 14'h2a0f;
    prog = 8'h96;
    wclk(6);
    host.transfer(24'h0200ff, rx);
    check("ground type status", rx, status(1'b0, 8'h3c));
    wclk(6);
    check("other command", {16'h0, ptype}, 24'h3c);
    host.noise();
    wclk(6);
    check("idle word", cmd_word, 24'h0200ff);
    $display("test transfer done");
  endtask

  task automatic t_int;
    int_en = 1'b1;
    wclk(6);
    gnd[0] = ~gnd[0];
    wclk(8);
    check("int on change", {23'h0, int_n_oe}, 24'h1);
    host.transfer(24'h0, rx);
    wclk(6);
    check("int released", {23'h0, int_n_oe}, 24'h0);
    fork
      host.transfer(24'h0, rx);
      #1000 gnd[1] = ~gnd[1];
    join
    wclk(6);
    check("int kept", {23'h0, int_n_oe}, 24'h1);
    int_en = 1'b0;
    $display("test interrupt done");
  endtask

  task automatic t_sleep;
    for (int k = 0; k < 4; k++) begin
      sleep_req = 1'b1;
      wclk(2);
      sleep_req = 1'b0;
      wclk(4);
      check("asleep", {23'h0, wake_n_oe}, 24'h0);
      if (k == 0) begin
        supply = 1'b0;
        host.transfer(24'h0, rx);
        wclk(6);
        check("no unpowered wake", {23'h0, wake_n_oe}, 24'h0);
        supply = 1'b1;
        wclk(4);
        host.transfer(24'h0, rx);
      end else if (k == 1) int_pull = 1'b1;
      else if (k == 2) wake_pull = 1'b1;
      else begin
        int_en = 1'b1;
        gnd[2] = ~gnd[2];
      end
      wclk(8);
      check("awake", {23'h0, wake_n_oe}, 24'h1);
      int_pull = 1'b0;
      wake_pull = 1'b0;
      int_en = 1'b0;
      wclk(4);
    end
    $display("test sleep done");
  endtask

  initial begin
    {reset, supply, therm} = 3'b111;
    {int_pull, wake_pull, int_en, sleep_req} = 4'h0;
    prog = 8'ha5;
    gnd = 14'h1234;
    repeat (6) @(posedge sys_clk);
    #1 reset = 1'b0;
    wclk(4);
    t_transfer();
    t_int();
    t_sleep();
    tally_and_finish();
  end
endmodule // tb
